// ### cap_list_pm_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [R01] Status word bit 4 flags capability list
// [R02] Flag read only, one when power entry
// [R03] First pointer read only, low bits zero
// [R04] No capabilities: flag zero, pointer ignored
// [R05] Entries dword aligned at or above 40h
// [R06] Each entry starts with identifier byte
// [R07] Power entry identifier reads 01h
// [R08] Second byte points to next entry
// [R09] Last entry returns zero next pointer
// [R10] Capability registers follow next pointer byte
// [R11] First pointer at 34h, or 14h type 2
// [R12] Pointer and flag same for every type
// [R13] Low half: identifier, then next pointer
// [R14] Capability and control words always present
// [R15] Bridge extension byte only for bridges
// [R16] Power reporting byte is optional
// [R17] Byte, word and dword accesses accepted
// [R18] Reserved writes complete, data dropped
// [R19] Reserved reads complete returning zero
// [R20] Entry offsets relative to entry start
// [R21] Dword compare plus byte enable lanes
module cap_list_pm_regs #(
  parameter logic [1:0]  HEADER_TYPE   = 2'h0,
  parameter logic        CAP_PRESENT   = 1'b1,
  parameter logic [7:0]  PM_BASE       = 8'h40,
  parameter logic [7:0]  NEXT_ENTRY    = 8'h00,
  parameter logic        IS_BRIDGE     = 1'b0,
  parameter logic        HAS_REPORT    = 1'b0,
  parameter logic [4:0]  PME_SUPPORT   = 5'h00,
  parameter logic        D2_SUPPORT    = 1'b0,
  parameter logic        D1_SUPPORT    = 1'b0,
  parameter logic        DEV_INIT      = 1'b0,
  parameter logic        PME_CLOCK     = 1'b0,
  parameter logic [15:0] CONTROL_WMASK = 16'h0003,
  parameter logic [7:0]  BRIDGE_WMASK  = 8'h00
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // Configuration request from the host
  input  wire cap_list_pkg::cfg_req_s cfg_req,
  // Configuration answer
  output logic                        cfg_ack_q,
  output logic [31:0]                 cfg_rdata_q,
  // Power state seen by the function
  output logic [15:0]                 control_word_q,
  output logic [7:0]                  bridge_ext_q,
  // Power reporting input from the function
  input  wire logic [7:0]             power_report
);

  // ==========================================================
  // Static layout
  // ==========================================================
  localparam logic [7:0] FIRST_PTR_OFS = (HEADER_TYPE == cap_list_pkg::HEADER_TYPE_CB) ?
                                         cap_list_pkg::FIRST_PTR_OFS_T2 : cap_list_pkg::FIRST_PTR_OFS_T01; // [R11]
  // Alignment is forced so a stray base can never break the chain walk
  localparam logic [7:0] ENTRY_BASE    = {PM_BASE[7:2], 2'b00}; // [R05]
  localparam logic [7:0] NEXT_ALIGNED  = {NEXT_ENTRY[7:2], 2'b00}; // [R08]
  localparam logic [7:0] FIRST_VALUE   = CAP_PRESENT ? ENTRY_BASE : cap_list_pkg::LIST_END_PTR; // [R03]
  localparam logic [7:0] ENTRY_DW0     = 8'(ENTRY_BASE + cap_list_pkg::REL_IDENTIFIER); // [R20]
  localparam logic [7:0] ENTRY_DW1     = 8'(ENTRY_BASE + cap_list_pkg::REL_CONTROL); // [R20]
  localparam logic [7:0] ENTRY_DW2     = 8'(ENTRY_BASE + cap_list_pkg::REL_POWER_REPORT); // [R20]
  localparam logic [15:0] CAP_WORD     = {PME_SUPPORT, D2_SUPPORT, D1_SUPPORT, 3'b000, DEV_INIT,
                                          1'b0, PME_CLOCK, cap_list_pkg::CAP_VERSION}; // [R14]
  localparam logic [7:0] BRIDGE_MASK_EFF = IS_BRIDGE ? BRIDGE_WMASK : 8'h00; // [R15]

  // ==========================================================
  // Decode helpers
  // ==========================================================
  // Dword hit: the byte offset's upper bits against the request
  function automatic logic dw_hit(input logic [5:0] dw, input logic [7:0] byte_ofs);
    dw_hit = (dw == byte_ofs[7:2]);
  endfunction : dw_hit

  // Byte enables widened to a data mask, so unrequested lanes read zero
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  logic hit_status;
  logic hit_first;
  logic hit_dw0;
  logic hit_dw1;
  logic hit_dw2;
  logic cfg_write;

  assign hit_status = dw_hit(cfg_req.dw_addr, cap_list_pkg::STATUS_WORD_OFS); // [R21]
  assign hit_first  = dw_hit(cfg_req.dw_addr, FIRST_PTR_OFS); // [R21]
  assign hit_dw0    = CAP_PRESENT && dw_hit(cfg_req.dw_addr, ENTRY_DW0); // [R21]
  assign hit_dw1    = CAP_PRESENT && dw_hit(cfg_req.dw_addr, ENTRY_DW1); // [R21]
  assign hit_dw2    = CAP_PRESENT && HAS_REPORT && dw_hit(cfg_req.dw_addr, ENTRY_DW2); // [R16]
  assign cfg_write  = cfg_req.valid && cfg_req.write;

  // ==========================================================
  // Read data assembly
  // ==========================================================
  logic [15:0] status_word;
  logic [31:0] rd_d;
  logic [15:0] control_d;
  logic [7:0]  bridge_d;
  logic [31:0] merged_dw1;
  logic [7:0]  report_q;

  assign status_word = {11'h000, CAP_PRESENT, 4'h0}; // [R01] [R02] [R04] [R12]

  always_comb begin
    rd_d = cap_list_pkg::READ_ZERO; // [R19]
    if (hit_status) begin
      rd_d[31:16] = status_word; // [R01]
    end
    if (hit_first) begin
      rd_d[8*FIRST_PTR_OFS[1:0] +: 8] = FIRST_VALUE; // [R03] [R12]
    end
    if (hit_dw0) begin
      rd_d = {CAP_WORD, NEXT_ALIGNED, cap_list_pkg::PM_IDENTIFIER}; // [R06] [R07] [R09] [R13]
    end
    if (hit_dw1) begin
      rd_d = {8'h00, (IS_BRIDGE ? bridge_ext_q : 8'h00), control_word_q}; // [R10] [R14] [R15]
    end
    if (hit_dw2) begin
      rd_d = {24'h00_0000, report_q}; // [R16]
    end
    rd_d = rd_d & lane_mask(cfg_req.byte_en); // [R17] [R21]
  end

  // ==========================================================
  // Answer: every access completes one cycle later
  // ==========================================================
  // No retry path exists, so reserved space never stalls the host
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ack_q   <= 1'b0;
      cfg_rdata_q <= cap_list_pkg::READ_ZERO;
    end else begin
      cfg_ack_q   <= cfg_req.valid; // [R18] [R19]
      cfg_rdata_q <= (cfg_req.valid && !cfg_req.write) ? rd_d : cap_list_pkg::READ_ZERO;
    end
  end

  // ==========================================================
  // Writable control dword of the entry
  // ==========================================================
  cfg_lane_merge #(
    .LANES      (4)
  ) u_merge (
    .old_value  ({8'h00, bridge_ext_q, control_word_q}),
    .wdata      (cfg_req.wdata),
    .byte_en    (cfg_req.byte_en),
    .write_mask ({8'h00, BRIDGE_MASK_EFF, CONTROL_WMASK}),
    .merged     (merged_dw1)
  );

  assign control_d = (cfg_write && hit_dw1) ? merged_dw1[15:0] : control_word_q; // [R17] [R21]
  assign bridge_d  = (cfg_write && hit_dw1) ? merged_dw1[23:16] : bridge_ext_q; // [R15]

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      control_word_q <= cap_list_pkg::CONTROL_RESET;
    end else begin
      control_word_q <= control_d; // [R14]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bridge_ext_q <= cap_list_pkg::BRIDGE_RESET;
    end else begin
      bridge_ext_q <= bridge_d; // [R15]
    end
  end

  // ==========================================================
  // Power reporting sample
  // ==========================================================
  // Sampled every cycle; a read sees the value one cycle old
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      report_q <= cap_list_pkg::REPORT_RESET;
    end else begin
      report_q <= HAS_REPORT ? power_report : cap_list_pkg::REPORT_RESET; // [R16]
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  logic [7:0] first_read;
  assign first_read = cfg_rdata_q[8*FIRST_PTR_OFS[1:0] +: 8];

  a_ack_every_req: // [R18]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg_req.valid |=> cfg_ack_q)
    else $error("Request not answered in one cycle");

  a_no_spurious_ack: // [R19]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cfg_req.valid |=> !cfg_ack_q)
    else $error("Answer without request");

  a_cap_flag_read: // [R01]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && hit_status && cfg_req.byte_en[2])
    |=> cfg_rdata_q[16 + cap_list_pkg::CAP_FLAG_BIT] == CAP_PRESENT)
    else $error("Capability flag read wrong");

  a_first_ptr_ok: // [R03]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && hit_first && cfg_req.byte_en[FIRST_PTR_OFS[1:0]])
    |=> (first_read[1:0] == 2'b00) && (!CAP_PRESENT || first_read >= cap_list_pkg::HEADER_LIMIT_OFS))
    else $error("First pointer misaligned or inside header");

  a_entry_id_byte: // [R07]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && hit_dw0 && cfg_req.byte_en[0])
    |=> cfg_rdata_q[7:0] == cap_list_pkg::PM_IDENTIFIER)
    else $error("Identifier byte wrong");

  a_next_ptr_byte: // [R09]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && hit_dw0 && cfg_req.byte_en[1])
    |=> (cfg_rdata_q[15:8] == NEXT_ALIGNED) && (cfg_rdata_q[9:8] == 2'b00))
    else $error("Next pointer byte wrong");

  a_reserved_zero: // [R19]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && !hit_status && !hit_first && !hit_dw0 && !hit_dw1 && !hit_dw2)
    |=> cfg_rdata_q == cap_list_pkg::READ_ZERO)
    else $error("Unmapped read not zero");

  a_reserved_write_drop: // [R18]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_write && !hit_dw1) |=> $stable(control_word_q) && $stable(bridge_ext_q))
    else $error("Write outside control dword changed state");

  a_control_write: // [R17]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_write && hit_dw1 && cfg_req.byte_en[0])
    |=> control_word_q[7:0] == (($past(control_word_q[7:0]) & ~CONTROL_WMASK[7:0])
                                | ($past(cfg_req.wdata[7:0]) & CONTROL_WMASK[7:0])))
    else $error("Control byte write lost");

  a_bridge_only: // [R15]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (bridge_ext_q & ~BRIDGE_MASK_EFF) == (cap_list_pkg::BRIDGE_RESET & ~BRIDGE_MASK_EFF))
    else $error("Fixed bridge extension bits moved");

  a_lane_masking: // [R21]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && cfg_req.byte_en == 4'h1)
    ##1 cfg_ack_q |-> cfg_rdata_q[31:8] == 24'h00_0000)
    else $error("Unrequested lanes not zero");

  a_status_low_zero: // [R01]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && hit_status && cfg_req.byte_en[2])
    |=> cfg_rdata_q[19:16] == 4'h0)
    else $error("Status low nibble not zero");

  a_pointer_lane_only: // [R19]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && hit_first)
    |=> (cfg_rdata_q & ~(32'h0000_00ff << (8 * FIRST_PTR_OFS[1:0]))) == 32'h0000_0000)
    else $error("Pointer dword carries other bytes");

  a_cap_version: // [R14]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && hit_dw0 && cfg_req.byte_en[2])
    |=> cfg_rdata_q[18:16] == cap_list_pkg::CAP_VERSION)
    else $error("Capability version wrong");

  a_cap_reserved_bits: // [R14]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && hit_dw0 && cfg_req.byte_en[2] && cfg_req.byte_en[3])
    |=> (cfg_rdata_q[24:22] == 3'b000) && !cfg_rdata_q[20])
    else $error("Capability reserved bits set");

  a_cap_support_bits: // [R10]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && hit_dw0 && cfg_req.byte_en[3])
    |=> cfg_rdata_q[31:25] == {PME_SUPPORT, D2_SUPPORT, D1_SUPPORT})
    else $error("Capability support bits wrong");

  a_control_hi_write: // [R17]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_write && hit_dw1 && cfg_req.byte_en[1])
    |=> control_word_q[15:8] == (($past(control_word_q[15:8]) & ~CONTROL_WMASK[15:8])
                                 | ($past(cfg_req.wdata[15:8]) & CONTROL_WMASK[15:8])))
    else $error("Control high byte write lost");

  a_bridge_write: // [R15]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_write && hit_dw1 && cfg_req.byte_en[2])
    |=> bridge_ext_q == (($past(bridge_ext_q) & ~BRIDGE_MASK_EFF)
                         | ($past(cfg_req.wdata[23:16]) & BRIDGE_MASK_EFF)))
    else $error("Bridge extension write wrong");

  a_lane_untouched: // [R21]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_write && hit_dw1 && !cfg_req.byte_en[0])
    |=> $stable(control_word_q[7:0]))
    else $error("Disabled lane was written");

  a_control_fixed_bits: // [R18]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (control_word_q & ~CONTROL_WMASK) == (cap_list_pkg::CONTROL_RESET & ~CONTROL_WMASK))
    else $error("Read-only control bits moved");

  a_control_read: // [R14]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && hit_dw1 && (cfg_req.byte_en[1:0] == 2'b11))
    |=> cfg_rdata_q[15:0] == control_word_q)
    else $error("Control word read wrong");

  a_bridge_read: // [R15]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && hit_dw1 && cfg_req.byte_en[2])
    |=> cfg_rdata_q[23:16] == bridge_ext_q)
    else $error("Bridge extension read wrong");

  a_dw1_top_zero: // [R19]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && hit_dw1)
    |=> cfg_rdata_q[31:24] == 8'h00)
    else $error("Unused byte of control dword not zero");

  a_report_read: // [R16]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && hit_dw2 && cfg_req.byte_en[0] && $past(rst_b))
    |=> cfg_rdata_q[7:0] == $past(power_report, 2))
    else $error("Power report read wrong");

  a_read_keeps_state: // [R17]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write)
    |=> $stable(control_word_q) && $stable(bridge_ext_q))
    else $error("Read changed register state");

  a_write_data_zero: // [R18]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg_write
    |=> cfg_rdata_q == cap_list_pkg::READ_ZERO)
    else $error("Write answered with data");

  a_idle_data_zero: // [R19]
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cfg_ack_q |-> cfg_rdata_q == cap_list_pkg::READ_ZERO)
    else $error("Read data without answer");

endmodule : cap_list_pm_regs

`default_nettype wire

// ### cap_list_pkg.sv
package cap_list_pkg;

  // ==========================================================
  // Configuration space locations
  // ==========================================================
  localparam logic [7:0] STATUS_WORD_OFS   = 8'h06;
  localparam int         CAP_FLAG_BIT      = 4;
  localparam logic [7:0] FIRST_PTR_OFS_T01 = 8'h34;
  localparam logic [7:0] FIRST_PTR_OFS_T2  = 8'h14;
  localparam logic [7:0] HEADER_LIMIT_OFS  = 8'h40;
  localparam logic [1:0] HEADER_TYPE_CB    = 2'h2;

  // ==========================================================
  // Power management entry layout, relative to the entry start
  // ==========================================================
  localparam logic [7:0] REL_IDENTIFIER    = 8'h00;
  localparam logic [7:0] REL_NEXT_POINTER  = 8'h01;
  localparam logic [7:0] REL_CAPABILITY    = 8'h02;
  localparam logic [7:0] REL_CONTROL       = 8'h04;
  localparam logic [7:0] REL_BRIDGE_EXT    = 8'h06;
  localparam logic [7:0] REL_POWER_REPORT  = 8'h08;

  // ==========================================================
  // Fixed values and reset values
  // ==========================================================
  localparam logic [7:0]  PM_IDENTIFIER    = 8'h01;
  localparam logic [7:0]  LIST_END_PTR     = 8'h00;
  localparam logic [2:0]  CAP_VERSION      = 3'h1;
  localparam logic [15:0] CONTROL_RESET    = 16'h0000;
  localparam logic [7:0]  BRIDGE_RESET     = 8'h00;
  localparam logic [7:0]  REPORT_RESET     = 8'h00;
  localparam logic [31:0] READ_ZERO        = 32'h0000_0000;

  // ==========================================================
  // Configuration request carrier
  // ==========================================================
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [5:0]  dw_addr;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } cfg_req_s;

endpackage : cap_list_pkg

// ### cfg_lane_merge.sv
`timescale 1ns/1ps
`default_nettype none

module cfg_lane_merge #(
  parameter int LANES = 4
) (
  // Current contents and write request
  input  wire logic [8*LANES-1:0] old_value,
  input  wire logic [8*LANES-1:0] wdata,
  input  wire logic [LANES-1:0]   byte_en,
  input  wire logic [8*LANES-1:0] write_mask,
  // Merged result
  output logic      [8*LANES-1:0] merged
);

  // ==========================================================
  // Per-lane merge
  // ==========================================================
  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane++) begin : g_lane
      logic [7:0] lane_mask;
      assign lane_mask = byte_en[lane] ? write_mask[8*lane +: 8] : 8'h00;
      assign merged[8*lane +: 8] = (old_value[8*lane +: 8] & ~lane_mask) | (wdata[8*lane +: 8] & lane_mask);
    end
  endgenerate

endmodule : cfg_lane_merge

`default_nettype wire

// ### cfg_host.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host model issuing configuration requests
// ==========================================================
module cfg_host (
  // Request toward the function
  output var cap_list_pkg::cfg_req_s cfg_req
);
  initial cfg_req = '0;

  // One request per call; the caller times it on the falling edge
  task automatic drive(input logic v, input logic w, input logic [5:0] a,
                       input logic [3:0] be, input logic [31:0] d);
    if (v) begin
      cfg_req = {v, w, a, be, d};
    end else begin
      // Released fields toggle so the function cannot lean on stale values
      cfg_req = {1'b0, ~cfg_req[42:0]};
    end
  endtask : drive
endmodule : cfg_host

`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ==========================================================
  // Signals and model state
  // ==========================================================
  logic                   sys_clk;
  logic                   rst_b;
  logic [7:0]             power_report;
  cap_list_pkg::cfg_req_s cfg_req;
  logic                   cfg_ack_q;
  logic [31:0]            cfg_rdata_q;
  logic [15:0]            control_word_q;
  logic [7:0]             bridge_ext_q;
  logic [15:0]            ctl;
  logic [7:0]             brg;
  logic [31:0]            lfsr;
  logic [31:0]            rd;
  logic [32:0]            expq[$];
  int                     n_fail;
  int                     compares;
  int                     cycles;

  cap_list_pm_regs #(.IS_BRIDGE(1'b1), .HAS_REPORT(1'b1), .PME_SUPPORT(5'h19),
    .DEV_INIT(1'b1), .BRIDGE_WMASK(8'hc0)) cap_list_pm_regs_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_ack_q(cfg_ack_q),
    .cfg_rdata_q(cfg_rdata_q), .control_word_q(control_word_q), .bridge_ext_q(bridge_ext_q),
    .power_report(power_report));

  cfg_host cfg_host_i (.cfg_req(cfg_req));

  // ==========================================================
  // Reference model
  // ==========================================================
  function automatic logic [7:0] mbyte(input logic [7:0] a);
    case (a)
      8'h06: return 8'h10;
      8'h34: return 8'h40;
      8'h40: return 8'h01;
      8'h41: return 8'h00;
      8'h42: return 8'h21;
      8'h43: return 8'hc8;
      8'h44: return ctl[7:0];
      8'h45: return ctl[15:8];
      8'h46: return brg;
      8'h48: return power_report;
      default: return 8'h00;
    endcase
  endfunction : mbyte

  task automatic mwrite(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h44) ctl[1:0] = d[1:0];
    if (a == 8'h46) brg[7:6] = d[7:6];
  endtask : mwrite

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // ==========================================================
  // Checking and closing
  // ==========================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // Answer of the previous request is checked before the next is driven,
  // so requests can follow each other every cycle
  task automatic op(input logic v, input logic w, input logic [5:0] a,
                    input logic [3:0] be, input logic [31:0] d);
    logic [32:0] e;
    @(negedge sys_clk);
    if (expq.size() > 0) begin
      e = expq.pop_front();
      chk({31'h0, cfg_ack_q}, {31'h0, e[32]});
      chk(cfg_rdata_q, e[31:0]);
      chk({8'h0, bridge_ext_q, control_word_q}, {8'h0, brg, ctl});
    end
    rd = cfg_rdata_q;
    cfg_host_i.drive(v, w, a, be, d);
    e = {v, 32'h0};
    for (int n = 0; n < 4; n++) begin
      if (v && be[n] && !w) e[8*n +: 8] = mbyte({a, 2'(n)});
      if (v && be[n] && w) mwrite({a, 2'(n)}, d[8*n +: 8]);
    end
    expq.push_back(e);
  endtask : op

  // ==========================================================
  // Clock, timeout and sequence
  // ==========================================================
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    rst_b = 1'b0;
    power_report = 8'h5a;
    lfsr = 32'hbd23;
    n_fail = 0;
    compares = 0;
    cycles = 0;
    ctl = 16'h0000;
    brg = 8'h00;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    chk({7'h00, cfg_ack_q, bridge_ext_q, control_word_q}, 32'h0);
    chk(cfg_rdata_q, 32'h0);
    $display("Test reset done");
    for (int i = 0; i < 64; i++) op(1'b1, 1'b0, 6'(i), 4'hf, 32'h0);
    op(1'b0, 1'b0, 6'h0, 4'h0, 32'h0);
    $display("Test map done");
    op(1'b1, 1'b0, 6'h0d, 4'h1, 32'h0);
    op(1'b0, 1'b0, 6'h0, 4'h0, 32'h0);
    op(1'b1, 1'b0, rd[7:2], 4'hf, 32'h0);
    op(1'b1, 1'b0, rd[7:2] + 6'h1, 4'hf, 32'h0);
    $display("Test walk done");
    repeat (400) begin
      lfsr = lfsr_next(lfsr);
      // Idle slots also move the report input, away from any read of it
      if (!(lfsr[0] | lfsr[1])) power_report = lfsr[31:24];
      op(lfsr[0] | lfsr[1], lfsr[2], lfsr[3] ? 6'h11 + {5'h0, lfsr[9]} : lfsr[13:8],
         lfsr[7:4], {lfsr[23:0], lfsr[31:24]});
    end
    op(1'b0, 1'b0, 6'h0, 4'h0, 32'h0);
    $display("Test random done");
    @(negedge sys_clk);
    rst_b = 1'b0;
    expq.delete();
    ctl = 16'h0000;
    brg = 8'h00;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    chk({7'h00, cfg_ack_q, bridge_ext_q, control_word_q}, 32'h0);
    op(1'b1, 1'b0, 6'h11, 4'hf, 32'h0);
    op(1'b0, 1'b0, 6'h0, 4'h0, 32'h0);
    $display("Test second reset done");
    finish_test();
  end
endmodule : tb_top

`default_nettype wire
